// ---- hw/psc_pkg.sv ----
package psc_pkg;
    // peripheral register addresses (data memory word addresses)
    localparam logic [15:0] PSC_ADDR_PIN_IRQ_EN_LOW   = 16'h2006;
    localparam logic [15:0] PSC_ADDR_PIN_FLAGS_LOW    = 16'h2007;
    localparam logic [15:0] PSC_ADDR_MODE_CONTROL     = 16'h2015;
    localparam logic [15:0] PSC_ADDR_SYSTEM_STATUS    = 16'h2016;
    localparam logic [15:0] PSC_ADDR_PERIPH_STATUS    = 16'h2017;
    localparam logic [15:0] PSC_ADDR_PIN_IRQ_EN_HIGH  = 16'h2046;
    localparam logic [15:0] PSC_ADDR_PIN_FLAG_HIGH    = 16'h2047;
    localparam logic [15:0] PSC_ADDR_SOFTWARE_TRIP    = 16'h2061;
    localparam logic [15:0] PSC_ADDR_SYSTEM_CONTROL   = 16'h3FFF;
    localparam logic [15:0] PSC_ADDR_IRQ_FORCE_CLEAR  = 16'h3F00;
    localparam logic [15:0] PSC_ADDR_IRQ_CONTROL      = 16'h3F01;
    localparam logic [15:0] PSC_ADDR_IRQ_MASK         = 16'h3F02;
    localparam logic [15:0] PSC_ADDR_IRQ_PENDING      = 16'h3F03;
    // field positions
    localparam int PSC_CLR_LSB        = 0;
    localparam int PSC_FORCE_LSB      = 8;
    localparam int PSC_NUM_IRQ        = 8;
    localparam int PSC_ICTL_RX_EDGE   = 0;
    localparam int PSC_ICTL_TX_EDGE   = 1;
    localparam int PSC_ICTL_PER_EDGE  = 2;
    localparam int PSC_ICTL_NEST      = 4;
    localparam int PSC_MODE_RX_SEL    = 4;
    localparam int PSC_MODE_UART      = 5;
    localparam int PSC_SYSC_ALT_FLAG  = 10;
    localparam int PSC_PSTAT_TRIP     = 0;
    localparam int PSC_PSTAT_SYNC     = 1;
    localparam int PSC_MASK_PERIPH    = 9;
    // core interrupt index, 7 = highest priority
    localparam logic [2:0] PSC_IRQ_TIMER  = 3'h0;
    localparam logic [2:0] PSC_IRQ_SW0    = 3'h3;
    localparam logic [2:0] PSC_IRQ_SW1    = 3'h4;
    localparam logic [2:0] PSC_IRQ_RX     = 3'h1;
    localparam logic [2:0] PSC_IRQ_TX     = 3'h2;
    localparam logic [2:0] PSC_IRQ_PERIPH = 3'h7;
    localparam logic [3:0] PSC_VEC_SLOT_SH = 4'h2;
    localparam logic [15:0] PSC_VEC_TOP    = 16'h002F;
    localparam logic [15:0] PSC_ZERO16     = 16'h0000;
    localparam logic [7:0]  PSC_ZERO8      = 8'h00;
    typedef enum logic [1:0] {
        PSC_ST_IDLE    = 2'b00,
        PSC_ST_SERVICE = 2'b01,
        PSC_ST_NESTED  = 2'b11
    } psc_state_t;
    // register write/read request from the core
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } psc_bus_t;
    // serial pin group
    typedef struct packed {
        logic rx_pin_a;
        logic rx_pin_b;
        logic rx_frame_sync;
        logic tx_frame_sync;
    } psc_spins_t;
endpackage

// ---- hw/psc_sysctl.sv ----
`timescale 1ns/100ps
module psc_sysctl
    import psc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire psc_bus_t    bus_in,
    output logic [15:0]      rdata_out,
    input  wire logic        trip_pin_n_in,
    input  wire logic        overcurrent_in,
    input  wire logic        pwm_sync_in,
    input  wire logic        watchdog_state_in,
    input  wire logic        pwm_timer_state_in,
    input  wire logic [8:0]  general_pin_in,
    input  wire psc_spins_t  spins_in,
    input  wire logic        core_flag_out_in,
    input  wire logic        serial_tx_output_in,
    input  wire logic        timer_event_in,
    input  wire logic        isr_exit_in,
    output logic             serial_rx_input_out,
    output logic             rx_frame_sync_int_out,
    output logic             flag_input_pin_out,
    output logic             flag_output_pin_out,
    output logic             tx_pin_oe_out,
    output logic             general_pin_5_out,
    output logic             general_pin_5_oe_out,
    output logic             peripheral_irq_line_n_out,
    output logic             vector_valid_out,
    output logic [15:0]      vector_addr_out
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change taken when stages 2 and 3 agree
    localparam int NSYNC = 15;
    // trip pin and both frame syncs rest high; resetting to idle avoids a false edge after reset
    localparam logic [NSYNC-1:0] SYNC_IDLE = 15'h000E;
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] s1_r, s2_r, s3_r, stable_r;
    assign raw_w = {general_pin_in, spins_in, trip_pin_n_in, pwm_sync_in};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    s1_r[gi]     <= SYNC_IDLE[gi];
                    s2_r[gi]     <= SYNC_IDLE[gi];
                    s3_r[gi]     <= SYNC_IDLE[gi];
                    stable_r[gi] <= SYNC_IDLE[gi];
                end else begin
                    s1_r[gi] <= raw_w[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        stable_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate
    wire       sync_now_w  = (s2_r[0] == s3_r[0]) ? s3_r[0] : stable_r[0];
    wire       trip_now_w  = (s2_r[1] == s3_r[1]) ? s3_r[1] : stable_r[1];
    wire [8:0] pins_now_w;
    assign pins_now_w = (s2_r[14:6] & s3_r[14:6]) | (~(s2_r[14:6] ^ s3_r[14:6]) & 9'h000)
                        | ((s2_r[14:6] ^ s3_r[14:6]) & stable_r[14:6]);
    wire       sync_ev_w  = sync_now_w & ~stable_r[0];
    wire       trip_ev_w;
    wire [8:0] pin_ev_w   = (pins_now_w ^ stable_r[14:6]);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [4:0]  ictl_r;
    logic [15:0] interrupt_mask_reg_r;
    logic [15:0] mode_r;
    logic [15:0] sysc_r;
    logic [7:0]  pen_lo_r;
    logic        pen_hi_r;
    logic [7:0]  pflag_lo_r;
    logic        pflag_hi_r;
    logic [1:0]  pstat_r;
    logic [7:0]  pend_r;
    logic [7:0]  pend_nxt;
    logic        oc_r;
    wire wr_w = bus_in.wr;
    wire rd_w = bus_in.rd;
    wire [15:0] a_w = bus_in.addr;
    wire sw_trip_w = wr_w && (a_w == PSC_ADDR_SOFTWARE_TRIP) && bus_in.wdata[0];
    assign trip_ev_w = (~trip_now_w & stable_r[1]) | (overcurrent_in & ~oc_r) | sw_trip_w;
    wire rd_pstat_w = rd_w && (a_w == PSC_ADDR_PERIPH_STATUS);
    wire rd_pflag_w = rd_w && ((a_w == PSC_ADDR_PIN_FLAGS_LOW) || (a_w == PSC_ADDR_PIN_FLAG_HIGH));
    wire [8:0] pin_hit_w = pin_ev_w & {pen_hi_r, pen_lo_r};

    // control register writes
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ictl_r   <= 5'h00;
            interrupt_mask_reg_r  <= PSC_ZERO16;
            mode_r   <= PSC_ZERO16;
            sysc_r   <= PSC_ZERO16;
            pen_lo_r <= PSC_ZERO8;
            pen_hi_r <= 1'b0;
            oc_r     <= 1'b0;
        end else begin
            oc_r <= overcurrent_in;
            if (wr_w && a_w == PSC_ADDR_IRQ_CONTROL) begin
                ictl_r <= bus_in.wdata[4:0];
            end else if (wr_w && a_w == PSC_ADDR_IRQ_MASK) begin
                interrupt_mask_reg_r <= bus_in.wdata;
            end else if (wr_w && a_w == PSC_ADDR_MODE_CONTROL) begin
                mode_r <= bus_in.wdata;
            end else if (wr_w && a_w == PSC_ADDR_SYSTEM_CONTROL) begin
                sysc_r <= bus_in.wdata;
            end else if (wr_w && a_w == PSC_ADDR_PIN_IRQ_EN_LOW) begin
                pen_lo_r <= bus_in.wdata[7:0];
            end else if (wr_w && a_w == PSC_ADDR_PIN_IRQ_EN_HIGH) begin
                pen_hi_r <= bus_in.wdata[0];
            end
        end
    end

    // peripheral flags: a new event beats a clearing read
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pstat_r    <= 2'h0;
            pflag_lo_r <= PSC_ZERO8;
            pflag_hi_r <= 1'b0;
        end else begin
            pstat_r[PSC_PSTAT_TRIP] <= trip_ev_w | (pstat_r[PSC_PSTAT_TRIP] & ~rd_pstat_w);
            pstat_r[PSC_PSTAT_SYNC] <= sync_ev_w | (pstat_r[PSC_PSTAT_SYNC] & ~rd_pstat_w);
            pflag_lo_r <= pin_hit_w[7:0] | (pflag_lo_r & {8{~rd_pflag_w}});
            pflag_hi_r <= pin_hit_w[8] | (pflag_hi_r & ~rd_pflag_w);
        end
    end
    wire per_any_w = (|pstat_r) | (|pflag_lo_r) | pflag_hi_r;

    ////////////////////////////////////////////////////////////////////////
    // serial pin routing
    // receive pin select
    wire rx_sel_w = mode_r[PSC_MODE_RX_SEL] ? stable_r[4] : stable_r[5];
    wire uart_w   = mode_r[PSC_MODE_UART];
    wire alt_w    = sysc_r[PSC_SYSC_ALT_FLAG];
    // uart tie: frame sync follows receive data
    wire rfs_int_w = uart_w ? rx_sel_w : stable_r[3];
    // frame syncs as interrupt inputs (active low)
    wire rx_line_w = alt_w & ~stable_r[3];
    wire tx_line_w = alt_w & ~stable_r[2];

    ////////////////////////////////////////////////////////////////////////
    // core interrupt pending and sensitivity
    logic [2:0] lvl_prev_r;
    wire  [2:0] lvl_w = {per_any_w, tx_line_w, rx_line_w};
    wire  [2:0] line_set_w;
    assign line_set_w = {ictl_r[PSC_ICTL_PER_EDGE] ? (lvl_w[2] & ~lvl_prev_r[2]) : lvl_w[2],
                         ictl_r[PSC_ICTL_TX_EDGE]  ? (lvl_w[1] & ~lvl_prev_r[1]) : lvl_w[1],
                         ictl_r[PSC_ICTL_RX_EDGE]  ? (lvl_w[0] & ~lvl_prev_r[0]) : lvl_w[0]};
    logic [15:0] ifc_w;
    assign ifc_w = (wr_w && a_w == PSC_ADDR_IRQ_FORCE_CLEAR) ? bus_in.wdata : PSC_ZERO16;
    logic [7:0] hw_set_w;
    logic [7:0] hold_w;
    // level lines keep a request only while asserted, so an acknowledged flag leaves nothing stale
    always_comb begin
        hw_set_w = PSC_ZERO8;
        hold_w   = 8'hFF;
        hold_w[PSC_IRQ_RX]     = ictl_r[PSC_ICTL_RX_EDGE] | lvl_w[0];
        hold_w[PSC_IRQ_TX]     = ictl_r[PSC_ICTL_TX_EDGE] | lvl_w[1];
        hold_w[PSC_IRQ_PERIPH] = ictl_r[PSC_ICTL_PER_EDGE] | lvl_w[2];
        // software interrupts have no hardware source
        hw_set_w[PSC_IRQ_TIMER]  = timer_event_in;
        hw_set_w[PSC_IRQ_RX]     = line_set_w[0];
        hw_set_w[PSC_IRQ_TX]     = line_set_w[1];
        hw_set_w[PSC_IRQ_PERIPH] = line_set_w[2];
    end
    // force and clear; a force on an idle level line lasts one cycle unless taken
    assign pend_nxt = ((pend_r & hold_w & ~ifc_w[PSC_CLR_LSB +: PSC_NUM_IRQ]) | ifc_w[PSC_FORCE_LSB +: PSC_NUM_IRQ])
                      | hw_set_w;

    ////////////////////////////////////////////////////////////////////////
    // priority pick and service sequencing
    logic [7:0] mask8_w;
    assign mask8_w = {interrupt_mask_reg_r[PSC_MASK_PERIPH], interrupt_mask_reg_r[6:0]};
    wire  [7:0] live_w = pend_r & mask8_w;
    logic [2:0] pick_w;
    always_comb begin
        pick_w = 3'h0;
        for (int i = 0; i < PSC_NUM_IRQ; i++) begin
            if (live_w[i]) begin
                pick_w = 3'(i);
            end
        end
    end
    psc_state_t state_r;
    logic [2:0] cur_r;
    // nesting permits preemption by a higher source
    wire may_take_w = (state_r == PSC_ST_IDLE) ||
                      (ictl_r[PSC_ICTL_NEST] && pick_w > cur_r);
    wire take_w = (|live_w) && may_take_w;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pend_r     <= PSC_ZERO8;
            lvl_prev_r <= 3'h0;
            state_r    <= PSC_ST_IDLE;
            cur_r      <= 3'h0;
        end else begin
            lvl_prev_r <= lvl_w;
            pend_r     <= take_w ? (pend_nxt & ~(8'h01 << pick_w)) : pend_nxt;
            case (state_r)
                PSC_ST_IDLE: begin
                    if (take_w) begin
                        state_r <= PSC_ST_SERVICE;
                        cur_r   <= pick_w;
                    end
                end
                PSC_ST_SERVICE: begin
                    if (take_w) begin
                        state_r <= PSC_ST_NESTED;
                        cur_r   <= pick_w;
                    end else if (isr_exit_in) begin
                        state_r <= PSC_ST_IDLE;
                    end
                end
                PSC_ST_NESTED: begin
                    if (isr_exit_in) begin
                        state_r <= PSC_ST_SERVICE;
                    end
                end
                default: state_r <= PSC_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    logic [15:0] rd_w16;
    assign rd_w16 = (a_w == PSC_ADDR_PERIPH_STATUS)   ? {14'h0000, pstat_r} :
                    (a_w == PSC_ADDR_PIN_FLAGS_LOW)   ? {8'h00, pflag_lo_r} :
                    (a_w == PSC_ADDR_PIN_FLAG_HIGH)   ? {15'h0000, pflag_hi_r} :
                    (a_w == PSC_ADDR_PIN_IRQ_EN_LOW)  ? {8'h00, pen_lo_r} :
                    (a_w == PSC_ADDR_PIN_IRQ_EN_HIGH) ? {15'h0000, pen_hi_r} :
                    (a_w == PSC_ADDR_SYSTEM_STATUS)   ?
                        {13'h0000, pwm_timer_state_in, watchdog_state_in, stable_r[1]} :
                    (a_w == PSC_ADDR_IRQ_CONTROL)     ? {11'h000, ictl_r} :
                    (a_w == PSC_ADDR_IRQ_MASK)        ? interrupt_mask_reg_r :
                    (a_w == PSC_ADDR_MODE_CONTROL)    ? mode_r :
                    (a_w == PSC_ADDR_SYSTEM_CONTROL)  ? sysc_r :
                    (a_w == PSC_ADDR_IRQ_PENDING)     ? {8'h00, pend_r} : PSC_ZERO16;

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rdata_out                 <= PSC_ZERO16;
            serial_rx_input_out       <= 1'b0;
            rx_frame_sync_int_out     <= 1'b0;
            flag_input_pin_out        <= 1'b0;
            flag_output_pin_out       <= 1'b0;
            tx_pin_oe_out             <= 1'b0;
            general_pin_5_out         <= 1'b0;
            general_pin_5_oe_out      <= 1'b0;
            peripheral_irq_line_n_out <= 1'b1;
            vector_valid_out          <= 1'b0;
            vector_addr_out           <= PSC_ZERO16;
        end else begin
            rdata_out                 <= rd_w ? rd_w16 : PSC_ZERO16;
            serial_rx_input_out       <= rx_sel_w;
            rx_frame_sync_int_out     <= rfs_int_w;
            flag_input_pin_out        <= alt_w & rx_sel_w;
            flag_output_pin_out       <= alt_w ? core_flag_out_in : serial_tx_output_in;
            tx_pin_oe_out             <= 1'b1;
            general_pin_5_out         <= core_flag_out_in;
            general_pin_5_oe_out      <= uart_w;
            peripheral_irq_line_n_out <= ~per_any_w;
            vector_valid_out          <= take_w;
            vector_addr_out           <= take_w ? (16'(pick_w) << PSC_VEC_SLOT_SH) : PSC_ZERO16;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_line_low;
        @(posedge clk_in) disable iff (!nrst_in) per_any_w |=> !peripheral_irq_line_n_out;
    endproperty
    a_line_low: assert property (p_line_low) else $error("irq line not low");
    property p_read_clear;
        @(posedge clk_in) disable iff (!nrst_in)
            (rd_pstat_w && !trip_ev_w && !sync_ev_w) |=> (pstat_r == 2'h0);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status not cleared");
    property p_set_wins;
        @(posedge clk_in) disable iff (!nrst_in) (rd_pflag_w && |pin_hit_w) |=> (|{pflag_hi_r, pflag_lo_r});
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on clear");
    property p_sw_force;
        @(posedge clk_in) disable iff (!nrst_in)
            (ifc_w[PSC_FORCE_LSB + PSC_IRQ_SW0] && !ifc_w[PSC_CLR_LSB + PSC_IRQ_SW0] && !take_w)
            |=> pend_r[PSC_IRQ_SW0];
    endproperty
    a_sw_force: assert property (p_sw_force) else $error("force ignored");
    property p_sw_only;
        @(posedge clk_in) disable iff (!nrst_in)
            (!pend_r[PSC_IRQ_SW1] && !ifc_w[PSC_FORCE_LSB + PSC_IRQ_SW1]) |=> !pend_r[PSC_IRQ_SW1];
    endproperty
    a_sw_only: assert property (p_sw_only) else $error("sw irq from hw");
    property p_vec_range;
        @(posedge clk_in) disable iff (!nrst_in) vector_valid_out |-> (vector_addr_out <= PSC_VEC_TOP);
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector out of table");
    property p_no_nest;
        @(posedge clk_in) disable iff (!nrst_in)
            (state_r == PSC_ST_SERVICE && !ictl_r[PSC_ICTL_NEST]) |=> (state_r != PSC_ST_NESTED);
    endproperty
    a_no_nest: assert property (p_no_nest) else $error("nested while disabled");
    property p_rx_sel;
        @(posedge clk_in) disable iff (!nrst_in)
            mode_r[PSC_MODE_RX_SEL] |=> (serial_rx_input_out == $past(stable_r[4]));
    endproperty
    a_rx_sel: assert property (p_rx_sel) else $error("wrong rx pin");
    c_trip: cover property (@(posedge clk_in) disable iff (!nrst_in) trip_ev_w ##[1:4] rd_pstat_w);
    c_pin: cover property (@(posedge clk_in) disable iff (!nrst_in) |pin_hit_w ##1 rd_pflag_w);
    c_nest: cover property (@(posedge clk_in) disable iff (!nrst_in) state_r == PSC_ST_NESTED);
endmodule

// ---- dv/psc_core_model.sv ----
`timescale 1ns/100ps
// core stand-in: each taken vector starts a routine that returns later
module psc_core_model (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic vector_valid_in,
    input  wire logic slow_in,
    output logic      isr_exit_out
);
    logic [3:0] wait_r;
    logic       busy_r;
    // slow routines hold the core long enough to show that nothing preempts
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            busy_r       <= 1'b0;
            wait_r       <= 4'h0;
            isr_exit_out <= 1'b0;
        end else begin
            isr_exit_out <= 1'b0;
            if (vector_valid_in) begin
                busy_r <= 1'b1;
                wait_r <= slow_in ? 4'hC : 4'h2;
            end else if (busy_r && wait_r == 4'h0) begin
                busy_r       <= 1'b0;
                isr_exit_out <= 1'b1;
            end else if (busy_r) begin
                wait_r <= wait_r - 4'h1;
            end
        end
    end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import psc_pkg::*;
    typedef struct packed {
        logic rxsel, uart, alt, rxa, rxb, cfl, txd, e_rx, e_fi, e_fo, e_oe, e_rfs;
    } psc_row_t;
    logic        clk_in = 1'b0;
    logic        nrst_in;
    psc_bus_t    bus;
    psc_spins_t  spins;
    logic [15:0] rdata, va, d;
    logic [8:0]  gpin;
    logic        trip_n, ovc, sync, wd, tmr, cflag, txd, tev, isr_exit, slow;
    logic        rx_o, rfs_o, fi_o, fo_o, txoe, g5, g5oe, irq_n, vv;
    int          bad_count = 0;
    int          n_checks = 0;
    psc_row_t    r;
    // pin routing cases: selects and pins, then rx, flag in, flag out, pin 5 oe, frame sync
    psc_row_t    rows [4] = '{12'b0001001_10101, 12'b1001000_00001, 12'b1010110_11101, 12'b0100110_00010};

    always #50 clk_in = ~clk_in;

    psc_sysctl u_psc_sysctl (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus), .rdata_out(rdata),
        .trip_pin_n_in(trip_n), .overcurrent_in(ovc), .pwm_sync_in(sync), .watchdog_state_in(wd),
        .pwm_timer_state_in(tmr), .general_pin_in(gpin), .spins_in(spins), .core_flag_out_in(cflag),
        .serial_tx_output_in(txd), .timer_event_in(tev), .isr_exit_in(isr_exit),
        .serial_rx_input_out(rx_o), .rx_frame_sync_int_out(rfs_o), .flag_input_pin_out(fi_o),
        .flag_output_pin_out(fo_o), .tx_pin_oe_out(txoe), .general_pin_5_out(g5),
        .general_pin_5_oe_out(g5oe), .peripheral_irq_line_n_out(irq_n), .vector_valid_out(vv),
        .vector_addr_out(va));
    psc_core_model u_psc_core_model (.clk_in(clk_in), .nrst_in(nrst_in), .vector_valid_in(vv),
        .slow_in(slow), .isr_exit_out(isr_exit));

    ////////////////////////////////////////////////////////////////////////////////
    // bus cycles: strobe held one edge, then released
    task automatic wr(input logic [15:0] a, input logic [15:0] w);
        @(posedge clk_in);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(posedge clk_in);
        bus <= '0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] q);
        @(posedge clk_in);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_in);
        bus <= '0;
        #1 q = rdata;
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // vector pulse lasts one cycle, so every cycle is looked at
    task automatic wait_vec(input logic [15:0] e);
        logic got;
        got = 1'b0;
        for (int i = 0; i < 60 && !got; i++) begin
            @(posedge clk_in);
            #1 got = (vv === 1'b1);
        end
        chk1("vector_seen", 1'b1, got);
        chk16("vector_addr", e, va);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard at 20000 cycles, far beyond the few hundred cycles the tests need
    initial begin
        #2000000;
        bad_count++;
        give_verdict;
    end

    initial begin
        nrst_in = 1'b0;
        bus = '0;
        spins = '{rx_pin_a: 1'b0, rx_pin_b: 1'b0, rx_frame_sync: 1'b1, tx_frame_sync: 1'b1};
        {trip_n, ovc, sync, wd, tmr, cflag, txd, tev, slow} = 9'h100;
        gpin = 9'h000;
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        #1 chk1("irq_line_n", 1'b1, irq_n);
        chk16("rdata", 16'h0000, rdata);
        chk1("vector_valid", 1'b0, vv);
        // routing table
        for (int i = 0; i < 4; i++) begin
            r = rows[i];
            wr(PSC_ADDR_MODE_CONTROL, (16'(r.rxsel) << PSC_MODE_RX_SEL) | (16'(r.uart) << PSC_MODE_UART));
            wr(PSC_ADDR_SYSTEM_CONTROL, 16'(r.alt) << PSC_SYSC_ALT_FLAG);
            @(posedge clk_in);
            spins.rx_pin_a <= r.rxa;
            spins.rx_pin_b <= r.rxb;
            cflag <= r.cfl;
            txd <= r.txd;
            repeat (6) @(posedge clk_in);
            #1 chk1("serial_rx", r.e_rx, rx_o);
            chk1("flag_in", r.e_fi, fi_o);
            chk1("flag_out", r.e_fo, fo_o);
            chk1("tx_oe", 1'b1, txoe);
            chk1("gp5_oe", r.e_oe, g5oe);
            if (r.e_oe) chk1("gp5", r.cfl, g5);
            if (!r.alt) chk1("rfs_int", r.e_rfs, rfs_o);
        end
        // alternate configuration: frame syncs drive masked core lines, rx edge, tx level
        wr(PSC_ADDR_SYSTEM_CONTROL, 16'h0400);
        wr(PSC_ADDR_IRQ_CONTROL, 16'h0001);
        spins.rx_frame_sync <= 1'b0;
        spins.tx_frame_sync <= 1'b0;
        repeat (8) @(posedge clk_in);
        rd(PSC_ADDR_IRQ_PENDING, d);
        chk16("pending_frame_sync", 16'h0006, d & 16'h00FF);
        wr(PSC_ADDR_IRQ_FORCE_CLEAR, 16'h0006);
        rd(PSC_ADDR_IRQ_PENDING, d);
        chk16("pending_level_kept", 16'h0004, d & 16'h00FF);
        spins.rx_frame_sync <= 1'b1;
        spins.tx_frame_sync <= 1'b1;
        repeat (6) @(posedge clk_in);
        rd(PSC_ADDR_IRQ_PENDING, d);
        chk16("pending_level_gone", 16'h0000, d & 16'h00FF);
        wr(PSC_ADDR_SYSTEM_CONTROL, 16'h0000);
        // core interrupt controls
        wr(PSC_ADDR_IRQ_CONTROL, 16'h0017);
        rd(PSC_ADDR_IRQ_CONTROL, d);
        chk16("irq_control", 16'h0017, d & 16'h001F);
        wr(PSC_ADDR_IRQ_CONTROL, 16'h0000);
        wr(PSC_ADDR_IRQ_MASK, 16'h0000);
        wr(PSC_ADDR_IRQ_FORCE_CLEAR, 16'h0800);
        rd(PSC_ADDR_IRQ_PENDING, d);
        chk16("pending_forced", 16'h0008, d & 16'h00FF);
        wr(PSC_ADDR_IRQ_FORCE_CLEAR, 16'h0008);
        rd(PSC_ADDR_IRQ_PENDING, d);
        chk16("pending_cleared", 16'h0000, d & 16'h00FF);
        wr(PSC_ADDR_IRQ_FORCE_CLEAR, 16'h1800);
        slow <= 1'b1;
        wr(PSC_ADDR_IRQ_MASK, 16'h0018);
        wait_vec(16'h0010);
        wait_vec(16'h000C);
        slow <= 1'b0;
        wr(PSC_ADDR_IRQ_MASK, 16'h0001);
        @(posedge clk_in);
        tev <= 1'b1;
        @(posedge clk_in);
        tev <= 1'b0;
        wait_vec(16'h0000);
        // peripheral events, peripheral line still masked
        @(posedge clk_in);
        sync <= 1'b1;
        repeat (6) @(posedge clk_in);
        #1 chk1("irq_line_sync", 1'b0, irq_n);
        rd(PSC_ADDR_PERIPH_STATUS, d);
        chk16("status_sync", 16'h0002, d & 16'h0003);
        @(posedge clk_in);
        #1 chk1("irq_line_ack", 1'b1, irq_n);
        sync <= 1'b0;
        repeat (6) @(posedge clk_in);
        #1 chk1("irq_line_sync_fall", 1'b1, irq_n);
        wr(PSC_ADDR_SOFTWARE_TRIP, 16'h0001);
        repeat (2) @(posedge clk_in);
        rd(PSC_ADDR_PERIPH_STATUS, d);
        chk16("status_swtrip", 16'h0001, d & 16'h0003);
        trip_n <= 1'b0;
        repeat (6) @(posedge clk_in);
        rd(PSC_ADDR_PERIPH_STATUS, d);
        chk16("status_pintrip", 16'h0001, d & 16'h0003);
        trip_n <= 1'b1;
        wd <= 1'b1;
        ovc <= 1'b1;
        repeat (6) @(posedge clk_in);
        rd(PSC_ADDR_PERIPH_STATUS, d);
        chk16("status_overcurrent", 16'h0001, d & 16'h0003);
        rd(PSC_ADDR_SYSTEM_STATUS, d);
        chk16("system_status", 16'h0003, d & 16'h0007);
        ovc <= 1'b0;
        // pin change on both edges, either flag read clears both
        wr(PSC_ADDR_PIN_IRQ_EN_LOW, 16'h0008);
        gpin <= 9'h008;
        repeat (6) @(posedge clk_in);
        #1 chk1("irq_line_pin", 1'b0, irq_n);
        rd(PSC_ADDR_PIN_FLAGS_LOW, d);
        chk16("pin_flags_low", 16'h0008, d & 16'h00FF);
        wr(PSC_ADDR_PIN_IRQ_EN_HIGH, 16'h0001);
        gpin <= 9'h100;
        repeat (6) @(posedge clk_in);
        rd(PSC_ADDR_PIN_FLAG_HIGH, d);
        chk16("pin_flag_high", 16'h0001, d & 16'h0001);
        rd(PSC_ADDR_PIN_FLAGS_LOW, d);
        chk16("pin_flags_low_cleared", 16'h0000, d & 16'h00FF);
        @(posedge clk_in);
        #1 chk1("irq_line_released", 1'b1, irq_n);
        rd(16'h2100, d);
        chk16("unmapped_read", 16'h0000, d);
        // peripheral line unmasked: pin 8 falls and vectors to its slot
        wr(PSC_ADDR_IRQ_MASK, 16'h0200);
        gpin <= 9'h000;
        wait_vec(16'h001C);
        repeat (4) @(posedge clk_in);
        rd(PSC_ADDR_PIN_FLAG_HIGH, d);
        chk16("pin_flag_fall", 16'h0001, d & 16'h0001);
        give_verdict;
    end
endmodule
